// ===== shared/prx_pkg.sv
// Shared constants and types of the proximity readout block
package prx_pkg;
    localparam int unsigned RESULT_W = 16;
    localparam int unsigned PERS_W = 4;
    localparam logic [7:0] ADDR_STATUS = 8'h13;
    localparam logic [7:0] ADDR_RES_LOW = 8'h18;
    localparam logic [7:0] ADDR_RES_HIGH = 8'h19;
    localparam logic [7:0] ADDR_OFFSET = 8'h1e;
    localparam int unsigned ST_SAT_BIT = 6;
    localparam int unsigned ST_INT_BIT = 5;
    localparam int unsigned ST_RSV_HI = 4;
    localparam int unsigned ST_RSV_LO = 2;
    localparam int unsigned ST_VALID_BIT = 1;
    localparam int unsigned OFS_SIGN_BIT = 7;
    localparam logic [7:0] OFFSET_RST = 8'h00;
    localparam logic [7:0] RDATA_RST = 8'h00;
    localparam logic [7:0] SHADOW_RST = 8'h00;
    localparam logic [1:0] DRIVE_WEAKEST = 2'h3;
    typedef enum {SENSE_OFF, SENSE_WAIT, SENSE_VALID} prx_sense_type;
endpackage

// ===== shared/prx_meas_if.sv
// Carrier for one measurement result passed between readout modules
`timescale 1ns/1ps
`default_nettype none
interface prx_meas_if #(parameter int unsigned W = 16);
    logic valid;
    logic [W-1:0] value;
    logic sat;
    modport src (output valid, output value, output sat);
    modport dst (input valid, input value, input sat);
endinterface
`default_nettype wire

// ===== hw/prx_offset_apply.sv
// Applies the sign-magnitude offset trim to each raw measurement
`timescale 1ns/1ps
`default_nettype none
module prx_offset_apply #(
    parameter int unsigned W = 16
) (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic clk_en_i,
    input wire logic [7:0] offset_i,
    input wire logic [1:0] gain_i,
    input wire logic [1:0] drive_i,
    input wire logic [7:0] pulses_i,
    prx_meas_if.dst raw,
    prx_meas_if.src adj
);
    localparam int unsigned SW = ((W > 21) ? W : 21) + 1;

    if (W < 8) begin : g_chk
        $error("prx_offset_apply: W too small");
    end

    logic [2:0] shift;
    // Stronger gain and drive give more counts per step, so the step grows with them
    assign shift = {1'b0, gain_i} + {1'b0, prx_pkg::DRIVE_WEAKEST - drive_i};

    function automatic logic [SW-1:0] step_of(input logic [7:0] ofs, input logic [2:0] sh,
                                              input logic [7:0] pul);
        logic [SW-1:0] s;
        s = SW'(SW'(ofs[6:0]) * SW'(pul));
        return s << sh;
    endfunction

    function automatic logic [W-1:0] apply_offset(input logic [W-1:0] v, input logic [7:0] ofs,
                                                  input logic [SW-1:0] step);
        logic [SW-1:0] wide;
        logic [SW-1:0] lim;
        wide = SW'(v);
        lim = SW'({W{1'b1}});
        // Clip rather than wrap so a large trim never flips near into far
        if (ofs[prx_pkg::OFS_SIGN_BIT])
        begin
            wide = wide + step;
            if (wide > lim)
            begin
                wide = lim;
            end
        end
        else if (step >= wide)
        begin
            wide = '0;
        end
        else
        begin
            wide = wide - step;
        end
        return wide[W-1:0];
    endfunction

    always_ff @(posedge sys_clk_i)
    begin
        if (sys_rst_i)
        begin
            adj.valid <= 1'b0;
            adj.value <= '0;
            adj.sat <= 1'b0;
        end
        else if (clk_en_i)
        begin
            adj.valid <= raw.valid;
            if (raw.valid)
            begin
                adj.value <= apply_offset(raw.value, offset_i,
                                          step_of(offset_i, shift, pulses_i));
                adj.sat <= raw.sat;
            end
        end
    end

    offset_neg_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        clk_en_i && raw.valid && !offset_i[prx_pkg::OFS_SIGN_BIT]
        |=> adj.value <= $past(raw.value))
        else $error("negative offset raised the result");
    offset_pos_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        clk_en_i && raw.valid && offset_i[prx_pkg::OFS_SIGN_BIT]
        |=> adj.value >= $past(raw.value))
        else $error("positive offset lowered the result");
    zero_mag_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        clk_en_i && raw.valid && offset_i[6:0] == 7'h00 |=> adj.value == $past(raw.value))
        else $error("zero magnitude changed the result");
    step_scale_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        clk_en_i && raw.valid && offset_i[prx_pkg::OFS_SIGN_BIT] && pulses_i != 8'h00
        |=> adj.value == {W{1'b1}} || SW'(adj.value) >= SW'($past(raw.value))
            + (SW'($past(offset_i[6:0])) << $past(shift)))
        else $error("offset step not scaled by gain and drive");
endmodule
`default_nettype wire

// ===== hw/prx_persist.sv
// Counts consecutive out-of-range results to pace the interrupt
`timescale 1ns/1ps
`default_nettype none
module prx_persist #(
    parameter int unsigned W = 16,
    parameter int unsigned PW = 4
) (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic clk_en_i,
    input wire logic [PW-1:0] pers_i,
    input wire logic [W-1:0] thr_low_i,
    input wire logic [W-1:0] thr_high_i,
    prx_meas_if.dst meas,
    output logic hit_o
);
    if (PW < 1 || PW > 8) begin : g_chk
        $error("prx_persist: PW out of range");
    end

    logic [PW-1:0] count_r;
    logic out_range;

    assign out_range = (meas.value < thr_low_i) || (meas.value > thr_high_i);

    always_ff @(posedge sys_clk_i)
    begin
        if (sys_rst_i)
        begin
            count_r <= '0;
            hit_o <= 1'b0;
        end
        else if (clk_en_i)
        begin
            hit_o <= 1'b0;
            if (meas.valid)
            begin
                if (!out_range)
                begin
                    count_r <= '0;
                    hit_o <= (pers_i == '0);
                end
                else if (pers_i == '0 || {1'b0, count_r} + 1'b1 >= {1'b0, pers_i})
                begin
                    // Saturate so a long run keeps interrupting on every valid result
                    count_r <= pers_i;
                    hit_o <= 1'b1;
                end
                else
                begin
                    count_r <= count_r + 1'b1;
                end
            end
        end
    end

    every_cycle_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        clk_en_i && meas.valid && pers_i == '0 |=> hit_o)
        else $error("zero persistence did not interrupt");
    in_range_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        clk_en_i && meas.valid && !out_range && pers_i != '0 |=> !hit_o)
        else $error("in-range result interrupted");
    first_count_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        clk_en_i && meas.valid && out_range && count_r == '0 && pers_i > PW'(1)
        |=> !hit_o)
        else $error("interrupt before persistence count");
endmodule
`default_nettype wire

// ===== hw/prx_readout.sv
// Proximity status, result readout with high-byte shadow, offset trim and interrupt pin
`timescale 1ns/1ps
`default_nettype none
module prx_readout #(
    parameter int unsigned RESULT_W = prx_pkg::RESULT_W,
    parameter int unsigned PERS_W = prx_pkg::PERS_W
) (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic clk_en_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_rd_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    input wire logic conv_done_i,
    input wire logic [RESULT_W-1:0] conv_value_i,
    input wire logic conv_saturated_i,
    input wire logic sensing_enable_i,
    input wire logic [1:0] sensing_gain_i,
    input wire logic [1:0] led_drive_strength_i,
    input wire logic [7:0] pulse_count_i,
    input wire logic [PERS_W-1:0] interrupt_persistence_i,
    input wire logic [RESULT_W-1:0] thr_low_i,
    input wire logic [RESULT_W-1:0] thr_high_i,
    input wire logic int_clear_i,
    input wire logic int_pin_i,
    output logic int_pin_o,
    output logic int_pin_oe_n_o
);
    if (RESULT_W != 16) begin : g_chk
        $error("prx_readout: result must be two bytes");
    end

    prx_meas_if #(.W(RESULT_W)) raw_if ();
    prx_meas_if #(.W(RESULT_W)) adj_if ();

    logic [7:0] offset_r;
    logic [RESULT_W-1:0] result_r;
    logic [7:0] shadow_r;
    logic sat_r;
    logic int_active_r;
    prx_pkg::prx_sense_type sense_r;
    prx_pkg::prx_sense_type sense_nxt;
    logic hit;
    logic rd_low;
    logic rd_high;
    logic [7:0] status_vec;
    logic [7:0] rdata_nxt;
    logic pin_meta_r;
    logic pin_sync_r;

    // Engine runs on this clock, so its strobes need no synchroniser
    assign raw_if.valid = conv_done_i && sensing_enable_i;
    assign raw_if.value = conv_value_i;
    assign raw_if.sat = conv_saturated_i;

    prx_offset_apply #(.W(RESULT_W)) u_offset (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .clk_en_i(clk_en_i),
        .offset_i(offset_r),
        .gain_i(sensing_gain_i),
        .drive_i(led_drive_strength_i),
        .pulses_i(pulse_count_i),
        .raw(raw_if.dst),
        .adj(adj_if.src)
    );

    prx_persist #(.W(RESULT_W), .PW(PERS_W)) u_persist (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .clk_en_i(clk_en_i),
        .pers_i(interrupt_persistence_i),
        .thr_low_i(thr_low_i),
        .thr_high_i(thr_high_i),
        .meas(adj_if.dst),
        .hit_o(hit)
    );

    assign rd_low = reg_rd_i && reg_addr_i == prx_pkg::ADDR_RES_LOW;
    assign rd_high = reg_rd_i && reg_addr_i == prx_pkg::ADDR_RES_HIGH;

    // Only the offset trim is writable; writes elsewhere, status included, fall away
    always_ff @(posedge sys_clk_i)
    begin
        if (sys_rst_i)
        begin
            offset_r <= prx_pkg::OFFSET_RST;
        end
        else if (clk_en_i && reg_wr_i && reg_addr_i == prx_pkg::ADDR_OFFSET)
        begin
            offset_r <= reg_wdata_i;
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (sys_rst_i)
        begin
            result_r <= '0;
            sat_r <= 1'b0;
        end
        else if (clk_en_i && adj_if.valid)
        begin
            result_r <= adj_if.value;
            sat_r <= adj_if.sat;
        end
    end

    always_comb
    begin
        case (sense_r)
            prx_pkg::SENSE_OFF:
                sense_nxt = sensing_enable_i ? prx_pkg::SENSE_WAIT : prx_pkg::SENSE_OFF;
            prx_pkg::SENSE_WAIT:
                sense_nxt = adj_if.valid ? prx_pkg::SENSE_VALID : prx_pkg::SENSE_WAIT;
            prx_pkg::SENSE_VALID:
                sense_nxt = prx_pkg::SENSE_VALID;
            default:
                sense_nxt = prx_pkg::SENSE_OFF;
        endcase
        if (!sensing_enable_i)
        begin
            sense_nxt = prx_pkg::SENSE_OFF;
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (sys_rst_i)
        begin
            sense_r <= prx_pkg::SENSE_OFF;
        end
        else if (clk_en_i)
        begin
            sense_r <= sense_nxt;
        end
    end

    // A new hit in the clearing cycle keeps the interrupt standing
    always_ff @(posedge sys_clk_i)
    begin
        if (sys_rst_i)
        begin
            int_active_r <= 1'b0;
        end
        else if (clk_en_i)
        begin
            if (hit)
            begin
                int_active_r <= 1'b1;
            end
            else if (int_clear_i)
            begin
                int_active_r <= 1'b0;
            end
        end
    end

    // Shadow decouples the high byte from results that land between the two reads
    always_ff @(posedge sys_clk_i)
    begin
        if (sys_rst_i)
        begin
            shadow_r <= prx_pkg::SHADOW_RST;
        end
        else if (clk_en_i && rd_low)
        begin
            shadow_r <= result_r[15:8];
        end
    end

    always_comb
    begin
        status_vec = 8'h00;
        status_vec[prx_pkg::ST_SAT_BIT] = sat_r;
        status_vec[prx_pkg::ST_INT_BIT] = int_active_r;
        status_vec[prx_pkg::ST_VALID_BIT] = (sense_r == prx_pkg::SENSE_VALID);
    end

    always_comb
    begin
        case (reg_addr_i)
            prx_pkg::ADDR_STATUS: rdata_nxt = status_vec;
            prx_pkg::ADDR_RES_LOW: rdata_nxt = result_r[7:0];
            prx_pkg::ADDR_RES_HIGH: rdata_nxt = shadow_r;
            prx_pkg::ADDR_OFFSET: rdata_nxt = offset_r;
            default: rdata_nxt = 8'h00;
        endcase
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (sys_rst_i)
        begin
            reg_rdata_o <= prx_pkg::RDATA_RST;
        end
        else if (clk_en_i && reg_rd_i)
        begin
            reg_rdata_o <= rdata_nxt;
        end
    end

    // Pin only ever sinks; the pull-up supplies the released level
    assign int_pin_o = 1'b0;
    assign int_pin_oe_n_o = !int_active_r;

    // Wire is shared with other drivers, so it is read only through two flops
    // Released level after reset matches the pull-up, so no false low follows
    always_ff @(posedge sys_clk_i)
    begin
        if (sys_rst_i)
        begin
            pin_meta_r <= 1'b1;
            pin_sync_r <= 1'b1;
        end
        else if (clk_en_i)
        begin
            pin_meta_r <= int_pin_i;
            pin_sync_r <= pin_meta_r;
        end
    end

    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (sys_rst_i);

    sequence rd_low_s;
        clk_en_i && rd_low;
    endsequence

    sequence rd_high_s;
        clk_en_i && rd_high;
    endsequence

    sequence status_wr_s;
        clk_en_i && reg_wr_i && reg_addr_i == prx_pkg::ADDR_STATUS && !adj_if.valid
            && !hit && !int_clear_i && (sensing_enable_i || sense_r == prx_pkg::SENSE_OFF);
    endsequence

    sequence pin_held_s;
        (clk_en_i && int_active_r) [*3];
    endsequence

    status_ro_a: assert property (status_wr_s |=> $stable(status_vec))
        else $error("status changed on host write");
    sat_flag_a: assert property (clk_en_i && adj_if.valid
        |=> status_vec[prx_pkg::ST_SAT_BIT] == $past(adj_if.sat))
        else $error("saturation flag does not follow measurement");
    int_flag_a: assert property (status_vec[prx_pkg::ST_INT_BIT] == !int_pin_oe_n_o)
        else $error("interrupt flag differs from pin drive");
    status_rsv_a: assert property (clk_en_i && reg_rd_i && reg_addr_i == prx_pkg::ADDR_STATUS
        |=> reg_rdata_o[prx_pkg::ST_RSV_HI:prx_pkg::ST_RSV_LO] == 3'b000)
        else $error("reserved status bits not zero");
    valid_set_a: assert property (clk_en_i && sensing_enable_i && conv_done_i
        ##1 clk_en_i && sensing_enable_i |=> status_vec[prx_pkg::ST_VALID_BIT])
        else $error("valid flag missing after cycle");
    valid_off_a: assert property (clk_en_i && !sensing_enable_i
        |=> !status_vec[prx_pkg::ST_VALID_BIT])
        else $error("valid flag without enable");
    low_byte_a: assert property (rd_low_s |=> reg_rdata_o == $past(result_r[7:0]))
        else $error("low byte read wrong");
    shadow_take_a: assert property (rd_low_s |=> shadow_r == $past(result_r[15:8]))
        else $error("shadow not loaded on low read");
    pair_match_a: assert property (rd_low_s ##1 rd_high_s
        |=> reg_rdata_o == $past(result_r[15:8], 2))
        else $error("high byte not paired with low byte");
    offset_rst_a: assert property (disable iff (1'b0) sys_rst_i
        |=> offset_r == prx_pkg::OFFSET_RST)
        else $error("offset not cleared by reset");
    pin_drive_a: assert property (clk_en_i && hit |=> !int_pin_oe_n_o && !int_pin_o)
        else $error("interrupt pin not pulled low");
    shadow_hold_a: assert property (!$stable(shadow_r) |-> $past(clk_en_i) && $past(rd_low))
        else $error("shadow changed without low read");
    rdata_hold_a: assert property (!(clk_en_i && reg_rd_i) |=> $stable(reg_rdata_o))
        else $error("read data changed without a read");
    int_clear_a: assert property (clk_en_i && int_clear_i && !hit
        |=> !status_vec[prx_pkg::ST_INT_BIT])
        else $error("interrupt flag kept after clear");
    // Only our own drive is checked; other devices may also pull the wire low
    pin_echo_a: assert property (pin_held_s |-> !pin_sync_r)
        else $error("interrupt wire not seen low while driven");
endmodule
`default_nettype wire

// ===== bench/prx_host_model.sv
// Host-side register master for the byte-wide register port
`timescale 1ns/1ps
`default_nettype none
module prx_host_model (
    input wire logic sys_clk_i,
    output logic [7:0] reg_addr_o,
    output logic reg_rd_o,
    output logic reg_wr_o,
    output logic [7:0] reg_wdata_o,
    input wire logic [7:0] reg_rdata_i
);
    initial
    begin
        reg_addr_o = 8'h00;
        reg_rd_o = 1'b0;
        reg_wr_o = 1'b0;
        reg_wdata_o = 8'h00;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk_i);
        reg_addr_o = a;
        reg_wdata_o = d;
        reg_wr_o = 1'b1;
        @(negedge sys_clk_i);
        reg_wr_o = 1'b0;
        // Released lines show the inverse so stale values never look live
        reg_addr_o = ~a;
        reg_wdata_o = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge sys_clk_i);
        reg_addr_o = a;
        reg_rd_o = 1'b1;
        @(negedge sys_clk_i);
        d = reg_rdata_i;
        reg_rd_o = 1'b0;
        reg_addr_o = ~a;
    endtask
    // Two-byte fetch, low byte first, address stepping as auto-increment does
    task automatic rd_pair(output logic [15:0] v);
        @(negedge sys_clk_i);
        reg_addr_o = prx_pkg::ADDR_RES_LOW;
        reg_rd_o = 1'b1;
        @(negedge sys_clk_i);
        v[7:0] = reg_rdata_i;
        reg_addr_o = prx_pkg::ADDR_RES_HIGH;
        @(negedge sys_clk_i);
        v[15:8] = reg_rdata_i;
        reg_rd_o = 1'b0;
        reg_addr_o = ~prx_pkg::ADDR_RES_HIGH;
    endtask
endmodule
`default_nettype wire

// ===== bench/prx_readout_bench.sv
// Self-checking bench for the proximity readout block
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp, msg) \
    begin \
        compares++; \
        if ((got) !== (exp)) \
        begin \
            failures++; \
            $display("[FAIL] %0t %s", $time, msg); \
        end \
    end
module prx_readout_bench;
    logic sys_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [7:0] reg_addr, reg_wdata, reg_rdata_o;
    logic reg_rd, reg_wr;
    logic conv_done = 1'b0;
    logic [15:0] conv_value = 16'h0000;
    logic conv_sat = 1'b0;
    logic sensing_enable = 1'b0;
    logic [1:0] gain = 2'h0;
    logic [1:0] drive = 2'h0;
    logic [7:0] pulses = 8'h00;
    logic [3:0] pers = 4'h0;
    logic [15:0] thr_low = 16'h0000;
    logic [15:0] thr_high = 16'h0000;
    logic int_clear = 1'b0;
    logic clk_en = 1'b1;
    logic int_pin_o, int_pin_oe_n_o;
    wire int_wire;
    int failures = 0;
    int compares = 0;
    // Pull-up on the interrupt wire
    assign int_wire = int_pin_oe_n_o ? 1'b1 : int_pin_o;
    always #20 sys_clk_i = ~sys_clk_i;
    prx_readout i_dut (
        .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en),
        .reg_addr_i(reg_addr), .reg_rd_i(reg_rd), .reg_wr_i(reg_wr),
        .reg_wdata_i(reg_wdata), .reg_rdata_o(reg_rdata_o),
        .conv_done_i(conv_done), .conv_value_i(conv_value), .conv_saturated_i(conv_sat),
        .sensing_enable_i(sensing_enable), .sensing_gain_i(gain),
        .led_drive_strength_i(drive), .pulse_count_i(pulses),
        .interrupt_persistence_i(pers), .thr_low_i(thr_low), .thr_high_i(thr_high),
        .int_clear_i(int_clear), .int_pin_i(int_wire), .int_pin_o(int_pin_o),
        .int_pin_oe_n_o(int_pin_oe_n_o)
    );
    prx_host_model i_host (
        .sys_clk_i(sys_clk_i), .reg_addr_o(reg_addr), .reg_rd_o(reg_rd),
        .reg_wr_o(reg_wr), .reg_wdata_o(reg_wdata), .reg_rdata_i(reg_rdata_o)
    );
    function automatic logic [15:0] exp_res(logic [15:0] raw, logic [7:0] ofs);
        int s;
        int r;
        s = int'(ofs[6:0]) * int'(pulses);
        s = s << (int'(gain) + 3 - int'(drive));
        r = ofs[7] ? int'(raw) + s : int'(raw) - s;
        if (r < 0)
        begin
            r = 0;
        end
        if (r > 65535)
        begin
            r = 65535;
        end
        return r[15:0];
    endfunction
    // Waits past the result, flag and interrupt pin updates
    task automatic conv(input logic [15:0] v, input logic s);
        @(negedge sys_clk_i);
        conv_done = 1'b1;
        conv_value = v;
        conv_sat = s;
        @(negedge sys_clk_i);
        conv_done = 1'b0;
        conv_value = ~v;
        conv_sat = ~s;
        repeat (3) @(negedge sys_clk_i);
    endtask
    task automatic clear_int();
        @(negedge sys_clk_i);
        int_clear = 1'b1;
        @(negedge sys_clk_i);
        int_clear = 1'b0;
    endtask
    task automatic summarize();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
        begin
            $display("DONE - PASS");
        end
        else
        begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial
    begin
        #(20000 * 40);
        failures++;
        summarize();
    end
    initial
    begin
        int seed;
        logic [7:0] d;
        logic [7:0] ofs;
        logic [15:0] raw;
        logic [15:0] v;
        logic sat;
        seed = $urandom(80);
        repeat (4) @(negedge sys_clk_i);
        sys_rst_i = 1'b0;
        `CHK(int_pin_oe_n_o, 1'b1, "pin not released after reset");
        i_host.rd(prx_pkg::ADDR_STATUS, d);
        `CHK(d, 8'h00, "status reset value");
        i_host.rd(prx_pkg::ADDR_OFFSET, d);
        `CHK(d, prx_pkg::OFFSET_RST, "offset reset value");
        i_host.wr(prx_pkg::ADDR_STATUS, 8'hff);
        i_host.rd(prx_pkg::ADDR_STATUS, d);
        `CHK(d, 8'h00, "status took a write");
        i_host.rd(8'h20, d);
        `CHK(d, 8'h00, "unmapped read");
        i_host.wr(prx_pkg::ADDR_OFFSET, 8'ha5);
        i_host.rd(prx_pkg::ADDR_OFFSET, d);
        `CHK(d, 8'ha5, "offset readback");
        sensing_enable = 1'b1;
        for (int i = 0; i < 24; i++)
        begin
            ofs = $urandom;
            gain = $urandom;
            drive = $urandom;
            pulses = $urandom_range(0, 4);
            raw = $urandom;
            sat = $urandom;
            if (i == 0)
            begin
                ofs = 8'h00;
            end
            if (i == 1)
            begin
                ofs = 8'hff;
                raw = 16'hfff0;
                pulses = 8'h01;
            end
            i_host.wr(prx_pkg::ADDR_OFFSET, ofs);
            conv(raw, sat);
            i_host.rd_pair(v);
            `CHK(v, exp_res(raw, ofs), "offset result");
            i_host.rd(prx_pkg::ADDR_STATUS, d);
            `CHK(d, {1'b0, sat, 1'b1, 3'b000, 1'b1, 1'b0}, "status flags");
            `CHK(int_pin_oe_n_o, ~d[5], "pin and flag differ");
            `CHK(int_pin_o, 1'b0, "pin data not low");
        end
        // Shadow must survive a new conversion between the two byte reads
        i_host.wr(prx_pkg::ADDR_OFFSET, 8'h00);
        conv(16'h1234, 1'b0);
        i_host.rd(prx_pkg::ADDR_RES_LOW, d);
        `CHK(d, 8'h34, "low byte");
        conv(16'habcd, 1'b0);
        i_host.rd(prx_pkg::ADDR_RES_HIGH, d);
        `CHK(d, 8'h12, "high byte not from shadow");
        i_host.rd(prx_pkg::ADDR_RES_HIGH, d);
        `CHK(d, 8'h12, "shadow changed");
        i_host.rd_pair(v);
        `CHK(v, 16'habcd, "pair read");
        // Persistence two: only a run of two out-of-range results raises the pin
        pers = 4'h2;
        thr_low = 16'd100;
        thr_high = 16'd200;
        conv(16'd150, 1'b0);
        clear_int();
        `CHK(int_pin_oe_n_o, 1'b1, "clear failed");
        conv(16'd300, 1'b0);
        conv(16'd150, 1'b0);
        conv(16'd300, 1'b0);
        `CHK(int_pin_oe_n_o, 1'b1, "early interrupt");
        conv(16'd300, 1'b0);
        `CHK(int_pin_oe_n_o, 1'b0, "missing interrupt");
        i_host.rd(prx_pkg::ADDR_STATUS, d);
        `CHK(d[5], 1'b1, "interrupt flag");
        `CHK(int_wire, 1'b0, "wire not pulled low");
        clear_int();
        `CHK(int_pin_oe_n_o, 1'b1, "pin held after clear");
        // Valid drops with enable, and results are ignored meanwhile
        @(negedge sys_clk_i);
        sensing_enable = 1'b0;
        @(negedge sys_clk_i);
        i_host.rd(prx_pkg::ADDR_STATUS, d);
        `CHK(d[1], 1'b0, "valid kept without enable");
        conv(16'h0f0f, 1'b1);
        i_host.rd(prx_pkg::ADDR_RES_LOW, d);
        `CHK(d, 8'h2c, "result taken while disabled");
        sensing_enable = 1'b1;
        conv(16'h0777, 1'b1);
        i_host.rd(prx_pkg::ADDR_STATUS, d);
        `CHK(d[1], 1'b1, "valid not set");
        `CHK(d[6], 1'b1, "saturation not set");
        // Frozen clock enable: neither the write nor the new result may land
        clk_en = 1'b0;
        i_host.wr(prx_pkg::ADDR_OFFSET, 8'h5a);
        conv(16'h0100, 1'b0);
        clk_en = 1'b1;
        i_host.rd(prx_pkg::ADDR_OFFSET, d);
        `CHK(d, 8'h00, "offset written while frozen");
        i_host.rd_pair(v);
        `CHK(v, 16'h0777, "result taken while frozen");
        summarize();
    end
endmodule
`default_nettype wire
